/* File: hdl/scss_pkg.sv */
package scss_pkg;

	// ------------------------------------------------------------
	// AXI4-Lite register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_STRAP    = 8'h00;
	localparam logic [7:0] REG_POWER    = 8'h04;
	localparam logic [7:0] REG_INT_STAT = 8'h08;
	localparam logic [7:0] REG_INT_MASK = 8'h0c;
	localparam logic [7:0] REG_CFG3F    = 8'h10;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------
	// Host bus decode
	// ------------------------------------------------------------
	localparam logic [15:0] PORT_IDX_PRI = 16'h03e0;
	localparam logic [15:0] PORT_DAT_PRI = 16'h03e1;
	localparam logic [15:0] PORT_IDX_SEC = 16'h03e2;
	localparam logic [15:0] PORT_DAT_SEC = 16'h03e3;
	localparam logic [5:0]  IDX_CFG      = 6'h3f;
	localparam int          NUM_INDEXES  = 64;
	localparam logic [1:0]  PH_CMD       = 2'h0;
	localparam logic [1:0]  PH_ADDR      = 2'h1;
	localparam logic [1:0]  PH_DATA      = 2'h2;

	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int          CFG_PU_CDVS  = 5;
	localparam int          CFG_PU_BVD   = 4;
	localparam int          CFG_PU_INPW  = 3;
	localparam logic [7:0]  CFG3F_RST    = 8'h00;
	localparam int          REQ_W        = 4;
	localparam int          EV_IRQ       = 0;
	localparam int          EV_DRQ       = 1;
	localparam int          EV_DBDONE    = 2;
	localparam int          EV_CFGWR     = 3;
	localparam int          EV_W         = 4;
	localparam logic [1:0]  TF_TRISTATE  = 2'h3;

	typedef enum logic [1:0] {SCSS_SLOT_A, SCSS_SLOT_B,
		SCSS_SLOT_C, SCSS_SLOT_D} scss_slot_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        io;
		logic        wr;
		logic        claim;
	} scss_hcyc_t;

	typedef struct packed {
		logic             captured;
		logic             test_mode;
		logic [1:0]       test_func;
		scss_slot_t       slot;
		logic             secondary;
		logic [3:0]       pwr;
		logic             pin_oe;
		logic             pu_strap;
		logic             pu_cdvs;
		logic             pu_bvd;
		logic             pu_inpw;
		logic [7:0]       cfg3f;
		logic [7:0]       index;
		scss_hcyc_t       cyc;
		logic             sel;
		logic [7:0]       hrdata;
		logic             hrvalid;
		logic [REQ_W-1:0] irq_prev;
		logic [REQ_W-1:0] drq_prev;
		logic             db_pend;
		logic             bus_req;
		logic             db_valid;
		logic [REQ_W-1:0] db_irq;
		logic [REQ_W-1:0] db_drq;
		logic [EV_W-1:0]  int_stat;
		logic [EV_W-1:0]  int_mask;
		logic             intr;
		logic             aw_ok;
		logic [7:0]       awaddr;
		logic             w_ok;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             aw_rdy;
		logic             w_rdy;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             ar_rdy;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} scss_state_t;

endpackage

/* File: hdl/scss_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Straps sampled once, held as configuration
// - Voltage control outputs high during reset
// - Card supply controls low during reset
// - Strap pull-ups active from reset until strap capture
// - 3.3 V line pulled up selects test
// - Pull-downs choose test function in test
// - Two straps choose slot, owning index quarter
// - 5 V strap high selects secondary ports
// - 64 indexes via the strap-selected index/data ports
// - Bit 5 set disables detect/sense pull-ups
// - Bit 4 controls battery/ready pull-ups
// - Bit 3 controls acknowledge/wait pull-ups
// - Eight controllers share bus by straps
// - Three host phases latched into internal cycle
// - Request bus to report interrupt changes
// - Request bus to report DMA request changes
// - Slot A claims index writes; others latch
module scss_top
	import scss_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             clk_en,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic [2:0]       s_axi_awprot,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	output logic [1:0]            s_axi_bresp,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic [2:0]       s_axi_arprot,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  irq,
	input  wire logic             program_voltage_ctl_i,
	output logic                  program_voltage_ctl_o,
	output logic                  program_voltage_ctl_oe,
	input  wire logic             supply_voltage_ctl_i,
	output logic                  supply_voltage_ctl_o,
	output logic                  supply_voltage_ctl_oe,
	input  wire logic             card_5v_enable_i,
	output logic                  card_5v_enable_o,
	output logic                  card_5v_enable_oe,
	input  wire logic             card_3v3_enable_i,
	output logic                  card_3v3_enable_o,
	output logic                  card_3v3_enable_oe,
	output logic                  strap_pullup_en,
	output logic                  detect_sense_pullup_en,
	output logic                  battery_ready_pullup_en,
	output logic                  ack_wait_pullup_en,
	output logic                  test_mode,
	output logic [1:0]            test_func,
	input  wire logic             host_strobe,
	input  wire logic [1:0]       host_phase,
	input  wire logic [15:0]      host_data,
	output logic                  host_sel,
	output logic [7:0]            host_rdata,
	output logic                  host_rvalid,
	input  wire logic [REQ_W-1:0] card_irq,
	input  wire logic [REQ_W-1:0] card_drq,
	output logic                  bus_request,
	input  wire logic             bus_grant,
	output logic                  report_valid,
	output logic [REQ_W-1:0]      report_irq,
	output logic [REQ_W-1:0]      report_drq
);

	// ------------------------------------------------------------
	// Local signals
	// ------------------------------------------------------------

	scss_state_t s_r;
	scss_state_t s_nxt;

	logic [15:0] idx_port;
	logic [15:0] dat_port;
	logic        own_data;
	logic        do_wr;
	logic        do_rd;
	logic [EV_W-1:0] ev;
	logic [REQ_W-1:0] irq_chg;
	logic [REQ_W-1:0] drq_chg;

	// ------------------------------------------------------------
	// Per-line change detect
	// ------------------------------------------------------------
	for (genvar g = 0; g < REQ_W; g++) begin : g_chg
		assign irq_chg[g] = card_irq[g] ^ s_r.irq_prev[g];
		assign drq_chg[g] = card_drq[g] ^ s_r.drq_prev[g];
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		ev = '0;
		s_nxt.hrvalid = 1'b0;
		s_nxt.db_valid = 1'b0;

		// ------------------------------------------------------------
		// Strap capture on the first enabled cycle after release
		// ------------------------------------------------------------
		if (!s_r.captured) begin
			s_nxt.captured  = 1'b1;
			s_nxt.test_mode = card_3v3_enable_i;
			s_nxt.test_func = {~supply_voltage_ctl_i,
				~program_voltage_ctl_i};
			s_nxt.slot = scss_slot_t'({~supply_voltage_ctl_i,
				~program_voltage_ctl_i});
			s_nxt.secondary = card_5v_enable_i;
			s_nxt.pu_strap  = 1'b0;
			s_nxt.pin_oe    = ~(card_3v3_enable_i &&
				(~supply_voltage_ctl_i & ~program_voltage_ctl_i));
		end

		// ------------------------------------------------------------
		// Base address from the 5 V strap: 2 port pairs, shared by all 4 slots
		// ------------------------------------------------------------
		idx_port = s_r.secondary ? PORT_IDX_SEC : PORT_IDX_PRI;
		dat_port = s_r.secondary ? PORT_DAT_SEC : PORT_DAT_PRI;

		// ------------------------------------------------------------
		// Data port ownership by index quarter
		// ------------------------------------------------------------
		own_data = (s_r.index[7:6] == 2'(s_r.slot));

		// ------------------------------------------------------------
		// Host bus phases
		// ------------------------------------------------------------
		if (s_r.captured && host_strobe) begin
			unique case (host_phase)
				PH_CMD: begin
					s_nxt.cyc.io = host_data[0];
					s_nxt.cyc.wr = host_data[1];
					s_nxt.cyc.claim = 1'b0;
				end
				PH_ADDR: begin
					s_nxt.cyc.addr = host_data;
					s_nxt.cyc.claim = s_r.cyc.io &&
						((host_data == idx_port &&
						s_r.slot == SCSS_SLOT_A) ||
						(host_data == dat_port && own_data));
					s_nxt.sel = s_nxt.cyc.claim;
				end
				PH_DATA: begin
					s_nxt.sel = 1'b0;
					if (s_r.cyc.io && s_r.cyc.addr == idx_port) begin
						if (s_r.cyc.wr) begin
							s_nxt.index = host_data[7:0];
						end else if (s_r.cyc.claim) begin
							s_nxt.hrdata = s_r.index;
							s_nxt.hrvalid = 1'b1;
						end
					end else if (s_r.cyc.claim) begin
						if (s_r.cyc.wr) begin
							if (s_r.index[5:0] == IDX_CFG) begin
								s_nxt.cfg3f = host_data[7:0];
								ev[EV_CFGWR] = 1'b1;
							end
						end else begin
							s_nxt.hrdata = (s_r.index[5:0] == IDX_CFG) ?
								s_r.cfg3f : 8'h00;
							s_nxt.hrvalid = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// Pull-up control from configuration byte
		// ------------------------------------------------------------
		s_nxt.pu_cdvs = ~s_nxt.cfg3f[CFG_PU_CDVS];
		s_nxt.pu_bvd  = s_nxt.cfg3f[CFG_PU_BVD];
		s_nxt.pu_inpw = s_nxt.cfg3f[CFG_PU_INPW];

		// ------------------------------------------------------------
		// Driveback of request line changes
		// ------------------------------------------------------------
		if (s_r.captured) begin
			s_nxt.irq_prev = card_irq;
			s_nxt.drq_prev = card_drq;
			ev[EV_IRQ] = |irq_chg;
			ev[EV_DRQ] = |drq_chg;
			if (ev[EV_IRQ] || ev[EV_DRQ]) begin
				s_nxt.db_pend = 1'b1;
			end
			if (s_r.bus_req && bus_grant) begin
				s_nxt.db_valid = 1'b1;
				s_nxt.db_irq = card_irq;
				s_nxt.db_drq = card_drq;
				s_nxt.db_pend = ev[EV_IRQ] || ev[EV_DRQ];
				ev[EV_DBDONE] = 1'b1;
			end
			s_nxt.bus_req = s_nxt.db_pend && !s_nxt.db_valid;
		end

		// ------------------------------------------------------------
		// AXI4-Lite write path
		// ------------------------------------------------------------
		if (s_axi_awvalid && s_r.aw_rdy) begin
			s_nxt.aw_ok = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.w_rdy) begin
			s_nxt.w_ok = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		do_wr = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
		if (do_wr) begin
			s_nxt.aw_ok = 1'b0;
			s_nxt.w_ok = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			unique case (s_r.awaddr)
				REG_POWER: begin
					if (s_r.wstrb[0]) begin
						s_nxt.pwr = s_r.wdata[3:0];
					end
				end
				REG_INT_STAT: begin
					if (s_r.wstrb[0]) begin
						s_nxt.int_stat = s_r.int_stat &
							~s_r.wdata[EV_W-1:0];
					end
				end
				REG_INT_MASK: begin
					if (s_r.wstrb[0]) begin
						s_nxt.int_mask = s_r.wdata[EV_W-1:0];
					end
				end
				REG_CFG3F: begin
					if (s_r.wstrb[0]) begin
						s_nxt.cfg3f = s_r.wdata[7:0];
						s_nxt.pu_cdvs = ~s_r.wdata[CFG_PU_CDVS];
						s_nxt.pu_bvd = s_r.wdata[CFG_PU_BVD];
						s_nxt.pu_inpw = s_r.wdata[CFG_PU_INPW];
					end
				end
				REG_STRAP: begin
				end
				default: begin
					s_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end

		// ------------------------------------------------------------
		// Sticky events, set wins over clear
		// ------------------------------------------------------------
		s_nxt.int_stat = s_nxt.int_stat | ev;
		s_nxt.intr = |(s_nxt.int_stat & s_nxt.int_mask);

		// ------------------------------------------------------------
		// AXI4-Lite read path
		// ------------------------------------------------------------
		do_rd = s_axi_arvalid && s_r.ar_rdy;
		if (do_rd) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				REG_STRAP: begin
					s_nxt.rdata[6:0] = {s_r.captured, s_r.test_mode,
						s_r.test_func, 2'(s_r.slot), s_r.secondary};
				end
				REG_POWER: begin
					s_nxt.rdata[3:0] = s_r.pwr;
				end
				REG_INT_STAT: begin
					s_nxt.rdata[EV_W-1:0] = s_r.int_stat;
				end
				REG_INT_MASK: begin
					s_nxt.rdata[EV_W-1:0] = s_r.int_mask;
				end
				REG_CFG3F: begin
					s_nxt.rdata[7:0] = s_r.cfg3f;
				end
				default: begin
					s_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end

		s_nxt.aw_rdy = !s_nxt.aw_ok && !s_nxt.bvalid;
		s_nxt.w_rdy = !s_nxt.w_ok && !s_nxt.bvalid;
		s_nxt.ar_rdy = !s_nxt.rvalid;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.pu_strap <= 1'b1;
			s_r.pu_cdvs <= 1'b1;
			s_r.cfg3f <= CFG3F_RST;
			s_r.pwr[2] <= 1'b1;
			s_r.pwr[3] <= 1'b1;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = s_r.aw_rdy;
	assign s_axi_wready = s_r.w_rdy;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.ar_rdy;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign irq = s_r.intr;

	// ------------------------------------------------------------
	// Power pins: program and supply voltage controls high from reset, card supplies low
	// ------------------------------------------------------------
	assign program_voltage_ctl_o = s_r.pwr[2];
	assign supply_voltage_ctl_o = s_r.pwr[3];
	assign card_5v_enable_o = s_r.pwr[0];
	assign card_3v3_enable_o = s_r.pwr[1];
	assign program_voltage_ctl_oe = s_r.pin_oe;
	assign supply_voltage_ctl_oe = s_r.pin_oe;
	assign card_5v_enable_oe = s_r.pin_oe;
	assign card_3v3_enable_oe = s_r.pin_oe;

	// ------------------------------------------------------------
	// Pull-up enables and test straps
	// ------------------------------------------------------------
	assign strap_pullup_en = s_r.pu_strap;
	assign detect_sense_pullup_en = s_r.pu_cdvs;
	assign battery_ready_pullup_en = s_r.pu_bvd;
	assign ack_wait_pullup_en = s_r.pu_inpw;
	assign test_mode = s_r.test_mode;
	assign test_func = s_r.test_func;

	// ------------------------------------------------------------
	// Host bus and driveback outputs
	// ------------------------------------------------------------
	assign host_sel = s_r.sel;
	assign host_rdata = s_r.hrdata;
	assign host_rvalid = s_r.hrvalid;
	assign bus_request = s_r.bus_req;
	assign report_valid = s_r.db_valid;
	assign report_irq = s_r.db_irq;
	assign report_drq = s_r.db_drq;

endmodule

/* File: bench/scss_props.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module scss_props
	import scss_pkg::*;
(
	input logic             aclk,
	input logic             aresetn,
	input logic             program_voltage_ctl_i,
	input logic             program_voltage_ctl_o,
	input logic             program_voltage_ctl_oe,
	input logic             supply_voltage_ctl_i,
	input logic             supply_voltage_ctl_o,
	input logic             card_5v_enable_o,
	input logic             card_3v3_enable_i,
	input logic             card_3v3_enable_o,
	input logic             strap_pullup_en,
	input logic             detect_sense_pullup_en,
	input logic             battery_ready_pullup_en,
	input logic             ack_wait_pullup_en,
	input logic             test_mode,
	input logic [1:0]       test_func,
	input logic             host_strobe,
	input logic [1:0]       host_phase,
	input logic             host_sel,
	input logic             host_rvalid,
	input logic [REQ_W-1:0] card_irq,
	input logic [REQ_W-1:0] card_drq,
	input logic             bus_request,
	input logic             bus_grant,
	input logic             report_valid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_RST_PINS: assert property (
		$rose(aresetn) |-> program_voltage_ctl_o && supply_voltage_ctl_o
		&& !card_5v_enable_o && !card_3v3_enable_o && strap_pullup_en)
		else $error("pin levels wrong in reset");
	AST_PU_OFF: assert property (
		aresetn && $past(aresetn) |-> !strap_pullup_en)
		else $error("strap pull-up on after capture");
	AST_TM_CAP: assert property (
		$rose(aresetn) |=> test_mode == $past(card_3v3_enable_i)
		&& test_func == ~{$past(supply_voltage_ctl_i),
		$past(program_voltage_ctl_i)})
		else $error("test strap capture wrong");
	AST_KEEP: assert property (
		aresetn && $past(aresetn) && $past(aresetn, 2)
		|-> $stable(test_mode) && $stable(test_func))
		else $error("captured straps changed");
	AST_OE: assert property (
		aresetn && $past(aresetn) |-> program_voltage_ctl_oe
		== !(test_mode && test_func == TF_TRISTATE))
		else $error("output enable wrong");
	AST_PU_DEF: assert property (
		$rose(aresetn) |-> detect_sense_pullup_en
		&& !battery_ready_pullup_en && !ack_wait_pullup_en)
		else $error("pull-up defaults wrong");
	AST_SEL: assert property (
		$rose(host_sel) |-> $past(host_strobe && host_phase == PH_ADDR))
		else $error("claim not after address phase");
	AST_RV: assert property (
		host_rvalid |-> $past(host_sel && host_strobe
		&& host_phase == PH_DATA))
		else $error("read data not after data phase");
	AST_BREQ: assert property (
		$changed(card_irq) || $changed(card_drq) |-> ##[1:3] bus_request)
		else $error("no bus request on change");
	AST_REP: assert property (
		bus_request && bus_grant |=> report_valid)
		else $error("no report after grant");
endmodule

/* File: bench/scss_slot_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Slot side: strap resistors behind the power pins
// ------------------------------------------------------------
module scss_slot_model (
	input  logic [3:0] strap,
	input  logic       program_voltage_ctl_o,
	input  logic       program_voltage_ctl_oe,
	input  logic       supply_voltage_ctl_o,
	input  logic       supply_voltage_ctl_oe,
	input  logic       card_5v_enable_o,
	input  logic       card_5v_enable_oe,
	input  logic       card_3v3_enable_o,
	input  logic       card_3v3_enable_oe,
	output logic       program_voltage_ctl_i,
	output logic       supply_voltage_ctl_i,
	output logic       card_5v_enable_i,
	output logic       card_3v3_enable_i
);
	// Driver wins, else resistor level
	assign program_voltage_ctl_i = program_voltage_ctl_oe ?
		program_voltage_ctl_o : strap[0];
	assign supply_voltage_ctl_i = supply_voltage_ctl_oe ?
		supply_voltage_ctl_o : strap[1];
	assign card_5v_enable_i = card_5v_enable_oe ? card_5v_enable_o : strap[2];
	assign card_3v3_enable_i = card_3v3_enable_oe ?
		card_3v3_enable_o : strap[3];
endmodule

/* File: bench/scss_top_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("Error %s exp %0h got %0h", n, e, g); \
	end \
end
module scss_top_tb
	import scss_pkg::*;
;
	logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready;
	logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	logic program_voltage_ctl_i, program_voltage_ctl_o;
	logic program_voltage_ctl_oe, supply_voltage_ctl_i;
	logic supply_voltage_ctl_o, supply_voltage_ctl_oe, card_5v_enable_i;
	logic card_5v_enable_o, card_5v_enable_oe, card_3v3_enable_i;
	logic card_3v3_enable_o, card_3v3_enable_oe, strap_pullup_en;
	logic detect_sense_pullup_en, battery_ready_pullup_en, test_mode;
	logic ack_wait_pullup_en, host_strobe, host_sel, host_rvalid;
	logic bus_request, bus_grant, report_valid;
	logic [7:0]       s_axi_awaddr, s_axi_araddr, host_rdata;
	logic [2:0]       s_axi_awprot, s_axi_arprot;
	logic [31:0]      s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]       s_axi_wstrb, strap;
	logic [1:0]       s_axi_bresp, s_axi_rresp, test_func, host_phase, rs, sl;
	logic [15:0]      host_data, ip;
	logic [REQ_W-1:0] card_irq, card_drq, report_irq, report_drq;
	logic             c;
	logic [7:0]       hr;
	int               err_total, num_checks, n;

	scss_top dut (.*);
	scss_slot_model slot (.*);

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic rst(input logic [3:0] s);
		@(posedge aclk);
		aresetn <= 1'b0;
		strap <= s;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic hcyc(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic cl, output logic [7:0] r);
		@(posedge aclk);
		host_strobe <= 1'b1;
		host_phase <= PH_CMD;
		host_data <= {14'h0, w, 1'b1};
		@(posedge aclk);
		host_phase <= PH_ADDR;
		host_data <= a;
		@(posedge aclk);
		host_phase <= PH_DATA;
		host_data <= {8'h0, d};
		#1 cl = host_sel;
		@(posedge aclk);
		host_strobe <= 1'b0;
		#1 r = host_rdata;
		if (!w) `CHK("rvalid", 1'b1, host_rvalid)
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog, tests
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	initial begin
		#400000;
		err_total++;
		$display("Error watchdog exp done got timeout");
		stop_test();
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, host_strobe, bus_grant} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awprot, s_axi_arprot, host_phase, host_data} = 24'h0;
		{card_irq, card_drq, strap} = 12'hfff;
		{card_irq, card_drq} = 8'h0;
		clk_en = 1'b1;
		s_axi_wstrb = 4'hf;
		for (int s = 0; s < 16; s++) begin
			rst(s[3:0]);
			sl = ~s[1:0];
			axi_rd(REG_STRAP, rd, rs);
			`CHK("strap", {25'h0, 1'b1, s[3], sl, sl, s[2]}, rd)
			`CHK("test", s[3], test_mode)
			`CHK("oe", !(s[3] && sl == 2'h3), program_voltage_ctl_oe)
			@(posedge aclk) strap <= ~strap;
			axi_rd(REG_STRAP, rd, rs);
			`CHK("kept", {25'h0, 1'b1, s[3], sl, sl, s[2]}, rd)
			if (s < 8) begin
				ip = s[2] ? PORT_IDX_SEC : PORT_IDX_PRI;
				hcyc(1'b1, ip, {sl, 6'h3f}, c, hr);
				`CHK("idx claim", sl == 2'h0, c)
				hcyc(1'b1, ip + 16'h1, 8'h38, c, hr);
				`CHK("dat claim", 1'b1, c)
				hcyc(1'b1, ip ^ 16'h3, 8'h00, c, hr);
				`CHK("alt pair", 1'b0, c)
				hcyc(1'b0, ip + 16'h1, 8'h00, c, hr);
				`CHK("dat rd", 8'h38, hr)
				`CHK("pullups", 3'b011, {detect_sense_pullup_en,
					battery_ready_pullup_en, ack_wait_pullup_en})
				hcyc(1'b1, ip, {sl + 2'h1, 6'h3f}, c, hr);
				hcyc(1'b1, ip + 16'h1, 8'h00, c, hr);
				`CHK("other slot", 1'b0, c)
				axi_rd(REG_CFG3F, rd, rs);
				`CHK("cfg3f", 32'h38, rd)
			end
		end
		$display("strap test done");
		rst(4'h3);
		axi_wr(REG_INT_MASK, 32'h1);
		@(posedge aclk);
		card_irq <= 4'h5;
		card_drq <= 4'h2;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!bus_request && n < 20);
		`CHK("breq", 1'b1, bus_request)
		bus_grant <= 1'b1;
		@(posedge aclk);
		bus_grant <= 1'b0;
		#1 `CHK("report", 9'h152, {report_valid, report_irq, report_drq})
		`CHK("irq on", 1'b1, irq)
		axi_wr(REG_INT_MASK, 32'h0);
		@(posedge aclk);
		#1 `CHK("irq masked", 1'b0, irq)
		axi_rd(REG_INT_STAT, rd, rs);
		`CHK("stat", 3'h7, rd[2:0])
		axi_wr(REG_INT_MASK, 32'h1);
		axi_wr(REG_INT_STAT, 32'hf);
		@(posedge aclk);
		#1 `CHK("irq clear", 1'b0, irq)
		axi_rd(8'h20, rd, rs);
		`CHK("unmapped", RESP_SLVERR, rs)
		$display("interrupt test done");
		stop_test();
	end
endmodule

bind scss_top scss_props u_props (.*);
